// ---- irq_prio_map.svh ----
// Register offsets, field positions and reset values of the priority block
`ifndef IRQ_PRIO_MAP_SVH
`define IRQ_PRIO_MAP_SVH
`define PRIO_REG0_OFS 8'h00
`define PRIO_REG1_OFS 8'h04
`define PRIO_REG2_OFS 8'h08
`define PRIO_REG3_OFS 8'h0C
`define EXT_CTRL_OFS 8'h10
`define LEVEL_STAT_OFS 8'h14
`define PRIO_RESET 32'hFFFFFFFF
`define EXT_CTRL_RESET 8'h00
`define EXT_CTRL_WMASK 8'hFC
`define SENS_B_HI 7
`define SENS_B_LO 6
`define POL_B_BIT 5
`define SENS_A_HI 4
`define SENS_A_LO 3
`define POL_A_BIT 2
`define NUM_VECTORS 14
`define NUM_EXT 4
`define LEVEL_RESET 2'h3
`endif

// ---- irq_prio_pkg.sv ----
// Types shared by the priority and external sensitivity block
package irq_prio_pkg;
    typedef enum logic [1:0] {
        LVL_2 = 2'b00,
        LVL_1 = 2'b01,
        LVL_0 = 2'b10,
        LVL_3 = 2'b11
    } level_e;
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
    } bus_phase_s;
    typedef struct packed {
        logic edge_hit;
        logic level_hit;
    } sense_hit_s;
endpackage : irq_prio_pkg

// ---- irq_prio.sv ----
// Software priority, current level tracking and external sensitivity
// Functional notes
// RULE_01: Keep a two-bit priority per vector, except reset and trap, in four registers.
// RULE_02: Encoding: level0=10, level1=01, level2=00, level3=11, also for current level.
// RULE_03: Writing pattern 10 into a priority field keeps the old field value.
// RULE_04: Field 0 is the highest vector pair, field 13 the lowest.
// RULE_05: Reset or trap servicing sets current level to 11.
// RULE_06: Priority raised for executing still-pending vector re-enters it; else level kept.
// RULE_07: Enable instruction loads 10 into current level.
// RULE_08: Disable instruction loads 11 into current level.
// RULE_09: Halt, pop flags, enable, disable, wait change level until next return.
// RULE_10: Jump-if-masked branches when level is 11; unmasked when it is not.
// RULE_11: Sensitivity and polarity bits configure four external sources.
// RULE_12: Falling, rising, both, falling+low; rising+high only on lines 0 and 2.
// RULE_13: Sensitivity and polarity writable only while current level is 11.
// RULE_14: Changing any sensitivity or polarity bit clears pending external requests.
// RULE_15: Bits 7:6 select lines 2 and 3; control register resets to zero.
// RULE_16: Line 2 codes 00/01/10/11 with inversion option by polarity bit B.
// RULE_17: Line 3 codes 00/01/10/11 fixed, ignore polarity bit B.
// RULE_18: Polarity bit B set inverts line 2 sensitivity; clear leaves it.
// RULE_19: Bits 4:3 select lines 0 and 1; line 0 inverted by bit 2.
// RULE_20: Software keeps control bits 1:0 cleared.
// RULE_21: Edges compare synchronized input with previous sample; level holds request.
// RULE_22: Halt and wait instructions set current level to 10.
`include "irq_prio_map.svh"
`default_nettype none

module irq_prio
    import irq_prio_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_in,
    // AHB-Lite slave
    input wire logic hsel_in,
    input wire logic [7:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // Core side
    input wire logic irq_enter_in,
    input wire logic [3:0] irq_vector_in,
    input wire logic trap_reset_enter_in,
    input wire logic enable_irq_instr_in,
    input wire logic disable_irq_instr_in,
    input wire logic halt_instr_in,
    input wire logic wait_irq_instr_in,
    input wire logic pop_flags_instr_in,
    input wire logic irq_return_instr_in,
    input wire logic [1:0] stacked_level_in,
    input wire logic jump_if_masked_instr_in,
    input wire logic jump_if_unmasked_instr_in,
    input wire logic [13:0] irq_pending_in,
    input wire logic [3:0] ext_ack_in,
    // External pins and block outputs
    input wire logic [3:0] ext_line_in,
    output logic [1:0] cur_level_out,
    output logic jump_taken_out,
    output logic reenter_out,
    output logic [3:0] ext_req_out
);

    // Priority order as a number: 0 lowest .. 3 highest
    function automatic logic [1:0] level_rank(input logic [1:0] code);
        level_rank = {~(code[1] ^ code[0]), code[0]};
    endfunction : level_rank

    function automatic sense_hit_s sense(
        input logic [1:0] code,
        input logic inv,
        input logic now,
        input logic prev
    );
        logic rise;
        logic fall;
        rise = now & ~prev;
        fall = ~now & prev;
        sense.edge_hit = 1'b0;
        sense.level_hit = 1'b0;
        case (code)
            2'b00: begin
                sense.edge_hit = inv ? rise : fall;
                sense.level_hit = inv ? now : ~now;
            end
            2'b01: sense.edge_hit = inv ? fall : rise;
            2'b10: sense.edge_hit = inv ? rise : fall;
            default: sense.edge_hit = rise | fall;
        endcase
    endfunction : sense

    logic [31:0] prio_ff;
    logic [31:0] nxt_prio;
    logic [7:0] ext_ctrl_ff;
    logic [7:0] nxt_ext_ctrl;
    level_e level_ff;
    level_e nxt_level;
    bus_phase_s phase_ff;
    logic [31:0] hrdata_ff;
    logic hreadyout_ff;
    logic hresp_ff;
    logic jump_taken_ff;
    logic reenter_ff;
    logic in_irq_ff;
    logic [3:0] active_vec_ff;
    logic [3:0] sync1_ff;
    logic [3:0] sync2_ff;
    logic [3:0] prev_ff;
    logic [3:0] pend_ff;
    logic [3:0] nxt_pend;
    logic [3:0] ext_req_ff;
    logic [3:0] edge_hit;
    logic [3:0] level_hit;
    logic wr_phase;
    logic ctrl_changed;
    logic [31:0] rd_mux;

    assign wr_phase = phase_ff.valid & phase_ff.write;

    // Bus address phase; zero wait states so hready is always ours
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            phase_ff <= '0;
        end else if (hready_in) begin
            phase_ff.valid <= hsel_in & htrans_in[1];
            phase_ff.write <= hwrite_in;
            phase_ff.addr <= haddr_in;
        end
    end

    // Next-state values for priority and control, so a read right behind a write sees the new data
    always_comb begin
        rd_mux = 32'h00000000;
        if (haddr_in == `PRIO_REG0_OFS) begin
            rd_mux = {24'h000000, nxt_prio[7:0]};
        end else if (haddr_in == `PRIO_REG1_OFS) begin
            rd_mux = {24'h000000, nxt_prio[15:8]};
        end else if (haddr_in == `PRIO_REG2_OFS) begin
            rd_mux = {24'h000000, nxt_prio[23:16]};
        end else if (haddr_in == `PRIO_REG3_OFS) begin
            rd_mux = {24'h000000, nxt_prio[31:24]};
        end else if (haddr_in == `EXT_CTRL_OFS) begin
            rd_mux = {24'h000000, nxt_ext_ctrl};
        end else if (haddr_in == `LEVEL_STAT_OFS) begin
            rd_mux = {30'h00000000, level_ff};
        end
    end

    // Read data is sampled at the address phase and stands in the data phase
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            hrdata_ff <= 32'h00000000;
            hreadyout_ff <= 1'b0;
            hresp_ff <= 1'b0;
        end else begin
            hreadyout_ff <= 1'b1;
            hresp_ff <= 1'b0;
            if (hready_in & hsel_in & htrans_in[1] & ~hwrite_in) begin
                hrdata_ff <= rd_mux;
            end
        end
    end

    // Priority fields, four per register; field i sits at bits 2i+1:2i
    always_comb begin
        logic [7:0] wbyte;
        int k;
        wbyte = hwdata_in[7:0];
        nxt_prio = prio_ff;
        k = -1;
        if (wr_phase) begin
            if (phase_ff.addr == `PRIO_REG0_OFS) begin
                k = 0;
            end else if (phase_ff.addr == `PRIO_REG1_OFS) begin
                k = 1;
            end else if (phase_ff.addr == `PRIO_REG2_OFS) begin
                k = 2;
            end else if (phase_ff.addr == `PRIO_REG3_OFS) begin
                k = 3;
            end
        end
        if (k >= 0) begin
            for (int f = 0; f < 4; f++) begin
                if (wbyte[2*f +: 2] != LVL_0) begin // [RULE_03]
                    nxt_prio[8*k + 2*f +: 2] = wbyte[2*f +: 2]; // [RULE_01] [RULE_04]
                end
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            prio_ff <= `PRIO_RESET;
        end else begin
            prio_ff <= nxt_prio;
        end
    end

    // Low two bits are reserved and kept at zero whatever is written
    always_comb begin
        nxt_ext_ctrl = ext_ctrl_ff;
        if (wr_phase && phase_ff.addr == `EXT_CTRL_OFS && level_ff == LVL_3) begin // [RULE_13]
            nxt_ext_ctrl = hwdata_in[7:0] & `EXT_CTRL_WMASK; // [RULE_20]
        end
    end
    assign ctrl_changed = nxt_ext_ctrl != ext_ctrl_ff; // [RULE_14]

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ext_ctrl_ff <= `EXT_CTRL_RESET; // [RULE_15]
        end else begin
            ext_ctrl_ff <= nxt_ext_ctrl;
        end
    end

    // Current level; the core issues at most one of these per cycle
    always_comb begin
        nxt_level = level_ff;
        if (trap_reset_enter_in) begin
            nxt_level = LVL_3; // [RULE_05]
        end else if (irq_enter_in) begin
            nxt_level = level_e'(prio_ff[2*irq_vector_in +: 2]); // [RULE_02]
        end else if (disable_irq_instr_in) begin
            nxt_level = LVL_3; // [RULE_08] [RULE_09]
        end else if (enable_irq_instr_in) begin
            nxt_level = LVL_0; // [RULE_07] [RULE_09]
        end else if (halt_instr_in | wait_irq_instr_in) begin
            nxt_level = LVL_0; // [RULE_22] [RULE_09]
        end else if (pop_flags_instr_in | irq_return_instr_in) begin
            nxt_level = level_e'(stacked_level_in); // [RULE_09]
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            level_ff <= level_e'(`LEVEL_RESET);
        end else begin
            level_ff <= nxt_level;
        end
    end

    // Tracks only the innermost vector; a nested return forgets the outer one
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            in_irq_ff <= 1'b0;
            active_vec_ff <= 4'h0;
        end else if (irq_enter_in) begin
            in_irq_ff <= 1'b1;
            active_vec_ff <= irq_vector_in;
        end else if (irq_return_instr_in | trap_reset_enter_in) begin
            in_irq_ff <= 1'b0;
        end
    end

    // Level itself is untouched by a priority write; the core re-enters
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            reenter_ff <= 1'b0;
        end else begin
            reenter_ff <= in_irq_ff & irq_pending_in[active_vec_ff]
                & (nxt_prio[2*active_vec_ff +: 2] != prio_ff[2*active_vec_ff +: 2])
                & (level_rank(nxt_prio[2*active_vec_ff +: 2]) > level_rank(level_ff)); // [RULE_06]
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            jump_taken_ff <= 1'b0;
        end else begin
            jump_taken_ff <= (jump_if_masked_instr_in & (level_ff == LVL_3))
                | (jump_if_unmasked_instr_in & (level_ff != LVL_3)); // [RULE_10]
        end
    end

    // Pins are asynchronous: two flops before any use
    // Not reset: they track the pins during reset, so no false edge or level at release
    always_ff @(posedge clk_in) begin
        sync1_ff <= ext_line_in;
        sync2_ff <= sync1_ff;
        prev_ff <= sync2_ff; // [RULE_21]
    end

    always_comb begin
        sense_hit_s h0;
        sense_hit_s h1;
        sense_hit_s h2;
        sense_hit_s h3;
        h0 = sense(ext_ctrl_ff[`SENS_A_HI:`SENS_A_LO], ext_ctrl_ff[`POL_A_BIT],
            sync2_ff[0], prev_ff[0]); // [RULE_19] [RULE_12]
        h1 = sense(ext_ctrl_ff[`SENS_A_HI:`SENS_A_LO], 1'b0,
            sync2_ff[1], prev_ff[1]); // [RULE_19]
        h2 = sense(ext_ctrl_ff[`SENS_B_HI:`SENS_B_LO], ext_ctrl_ff[`POL_B_BIT],
            sync2_ff[2], prev_ff[2]); // [RULE_16] [RULE_18]
        h3 = sense(ext_ctrl_ff[`SENS_B_HI:`SENS_B_LO], 1'b0,
            sync2_ff[3], prev_ff[3]); // [RULE_17] [RULE_11]
        edge_hit = {h3.edge_hit, h2.edge_hit, h1.edge_hit, h0.edge_hit};
        level_hit = {h3.level_hit, h2.level_hit, h1.level_hit, h0.level_hit};
    end

    // A new edge beats both an ack and a control change in the same cycle
    assign nxt_pend = edge_hit | (pend_ff & ~ext_ack_in & {4{~ctrl_changed}}); // [RULE_14] [RULE_21]

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            pend_ff <= 4'h0;
            ext_req_ff <= 4'h0;
        end else begin
            pend_ff <= nxt_pend;
            ext_req_ff <= nxt_pend | level_hit; // [RULE_21]
        end
    end

    assign hrdata_out = hrdata_ff;
    assign hreadyout_out = hreadyout_ff;
    assign hresp_out = hresp_ff;
    assign cur_level_out = level_ff;
    assign jump_taken_out = jump_taken_ff;
    assign reenter_out = reenter_ff;
    assign ext_req_out = ext_req_ff;

    a_trap_sets_l3: assert property (@(posedge clk_in) disable iff (reset_in)
        trap_reset_enter_in |=> cur_level_out == 2'b11)
        else $error("trap did not set level 3"); // [RULE_05]

    a_enable_sets_l0: assert property (@(posedge clk_in) disable iff (reset_in)
        enable_irq_instr_in && !trap_reset_enter_in && !irq_enter_in
        && !disable_irq_instr_in |=> cur_level_out == 2'b10)
        else $error("enable did not load 10"); // [RULE_07]

    a_disable_sets_l3: assert property (@(posedge clk_in) disable iff (reset_in)
        disable_irq_instr_in && !trap_reset_enter_in && !irq_enter_in
        |=> cur_level_out == 2'b11)
        else $error("disable did not load 11"); // [RULE_08]

    a_halt_sets_l0: assert property (@(posedge clk_in) disable iff (reset_in)
        (halt_instr_in || wait_irq_instr_in) && !trap_reset_enter_in && !irq_enter_in
        && !disable_irq_instr_in |=> cur_level_out == 2'b10)
        else $error("halt or wait did not load 10"); // [RULE_22]

    a_jump_masked: assert property (@(posedge clk_in) disable iff (reset_in)
        jump_if_masked_instr_in && !jump_if_unmasked_instr_in
        |=> jump_taken_out == ($past(cur_level_out) == 2'b11))
        else $error("masked jump wrong"); // [RULE_10]

    a_ctrl_locked: assert property (@(posedge clk_in) disable iff (reset_in)
        level_ff != LVL_3 |=> $stable(ext_ctrl_ff))
        else $error("control changed below level 3"); // [RULE_13]

    a_ctrl_low_zero: assert property (@(posedge clk_in) disable iff (reset_in)
        ext_ctrl_ff[1:0] == 2'b00)
        else $error("reserved control bits set"); // [RULE_20]

    a_level0_kept: assert property (@(posedge clk_in) disable iff (reset_in)
        wr_phase && phase_ff.addr == `PRIO_REG0_OFS && hwdata_in[1:0] == 2'b10
        |=> prio_ff[1:0] == $past(prio_ff[1:0]))
        else $error("level 0 pattern was stored"); // [RULE_03]

    a_change_clears: assert property (@(posedge clk_in) disable iff (reset_in)
        ctrl_changed && edge_hit == 4'h0 |=> pend_ff == 4'h0)
        else $error("control change kept pending"); // [RULE_14]

    a_edge_requests: assert property (@(posedge clk_in) disable iff (reset_in)
        edge_hit[3] |=> ext_req_out[3] && pend_ff[3])
        else $error("edge did not raise request"); // [RULE_21]

endmodule : irq_prio

`default_nettype wire

// ---- core_model.sv ----
// Behavioural core and pin model driving the block's core-side inputs
`default_nettype none
module core_model (
    input wire logic clk_in,
    output logic enter_out,
    output logic trap_out,
    output logic [3:0] vec_out,
    output logic [7:0] instr_out,
    output logic [1:0] stk_out,
    output logic [13:0] pend_out,
    output logic [3:0] ack_out,
    output logic [3:0] line_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        enter_out = 1'b0;
        trap_out = 1'b0;
        vec_out = 4'h0;
        instr_out = 8'h00;
        stk_out = 2'h0;
        pend_out = 14'h0000;
        ack_out = 4'h0;
        line_out = 4'hF;
    end
    // Bits: enable, disable, halt, wait, pop, return, jump masked, jump unmasked
    task instr(input int b, input logic [1:0] stk);
        @(posedge clk_in);
        instr_out <= 8'h01 << b;
        stk_out <= stk;
        @(posedge clk_in);
        instr_out <= 8'h00;
    endtask : instr
    task enter(input logic trap, input logic [3:0] v);
        @(posedge clk_in);
        trap_out <= trap;
        enter_out <= ~trap;
        vec_out <= v;
        @(posedge clk_in);
        trap_out <= 1'b0;
        enter_out <= 1'b0;
    endtask : enter
    task ack();
        @(posedge clk_in);
        ack_out <= 4'hF;
        @(posedge clk_in);
        ack_out <= 4'h0;
    endtask : ack
    task lines(input logic [3:0] v);
        @(posedge clk_in);
        line_out <= v;
    endtask : lines
    task pend(input logic [13:0] v);
        @(posedge clk_in);
        pend_out <= v;
    endtask : pend
endmodule : core_model
`default_nettype wire

// ---- test_irq_priority_and_ext_sensitivity.sv ----
// Self-checking bench for the priority and sensitivity block
`default_nettype none
module test_irq_priority_and_ext_sensitivity;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hready, hresp, jump, reent, enter, trap;
    logic [3:0] vec, ack, pins, req;
    logic [7:0] ins;
    logic [1:0] stk, lvl;
    logic [13:0] pend;
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;
    always #50 clk_in = ~clk_in;
    core_model m (.clk_in(clk_in), .enter_out(enter), .trap_out(trap), .vec_out(vec),
        .instr_out(ins), .stk_out(stk), .pend_out(pend), .ack_out(ack), .line_out(pins));
    irq_prio dut (.clk_in(clk_in), .reset_in(reset_in), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
        .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
        .irq_enter_in(enter), .irq_vector_in(vec), .trap_reset_enter_in(trap),
        .enable_irq_instr_in(ins[0]), .disable_irq_instr_in(ins[1]), .halt_instr_in(ins[2]),
        .wait_irq_instr_in(ins[3]), .pop_flags_instr_in(ins[4]),
        .irq_return_instr_in(ins[5]), .stacked_level_in(stk),
        .jump_if_masked_instr_in(ins[6]), .jump_if_unmasked_instr_in(ins[7]),
        .irq_pending_in(pend), .ext_ack_in(ack), .ext_line_in(pins), .cur_level_out(lvl),
        .jump_taken_out(jump), .reenter_out(reent), .ext_req_out(req));
    task give_verdict();
        if (mismatches == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict
    // Whole run needs under 2000 cycles
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 6000) begin
            mismatches++;
            give_verdict();
        end
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk_in);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge clk_in); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_in); while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask : wr
    task rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(r, exp);
    endtask : rdc
    task lv(input logic [1:0] e);
        @(posedge clk_in);
        chk(lvl, e);
    endtask : lv
    task t_reset();
        for (int k = 0; k < 4; k++) rdc(8'(k * 4), 32'hFF);
        rdc(8'h10, 32'h0);
        wr(8'h20, 32'hFF);
        rdc(8'h20, 32'h0);
        chk(hresp, 1'b0);
        chk(lvl, 2'h3);
    endtask : t_reset
    task t_prio();
        wr(8'h00, 32'hCF);
        rdc(8'h00, 32'hCF);
        wr(8'h00, 32'h64);
        rdc(8'h00, 32'h44);
        wr(8'h00, 32'hE2);
        rdc(8'h00, 32'hC0);
        wr(8'h08, 32'h5A);
        rdc(8'h08, 32'h5F);
    endtask : t_prio
    task t_instr();
        int b[8];
        logic [1:0] e[8];
        b = '{1, 0, 1, 2, 1, 3, 4, 5};
        e = '{2'h3, 2'h2, 2'h3, 2'h2, 2'h3, 2'h2, 2'h1, 2'h0};
        for (int k = 0; k < 8; k++) begin
            m.instr(b[k], e[k]);
            lv(e[k]);
        end
        for (int k = 0; k < 4; k++) begin
            m.instr(k < 2 ? 1 : 0, 2'h0);
            m.instr(6 + k % 2, 2'h0);
            @(posedge clk_in);
            chk(jump, (k % 2 == 0) == (k < 2));
        end
    endtask : t_instr
    task t_map();
        wr(8'h00, 32'hFC);
        m.enter(1'b0, 4'h0);
        lv(2'h0);
        wr(8'h0C, 32'hF7);
        m.enter(1'b0, 4'hD);
        lv(2'h1);
        m.enter(1'b1, 4'h0);
        lv(2'h3);
    endtask : t_map
    task t_reenter();
        logic seen;
        wr(8'h04, 32'hF7);
        m.pend(14'h0020);
        m.enter(1'b0, 4'h5);
        lv(2'h1);
        // Raise first, then lower: only the raise may re-enter
        for (int k = 0; k < 2; k++) begin
            wr(8'h04, k ? 32'hF7 : 32'hF3);
            seen = 1'b0;
            repeat (3) begin
                @(posedge clk_in);
                seen = seen | reent;
            end
            chk(seen, k == 0);
            chk(lvl, 2'h1);
        end
        m.pend(14'h0000);
    endtask : t_reenter
    task t_guard();
        m.instr(0, 2'h0);
        wr(8'h10, 32'h48);
        rdc(8'h10, 32'h0);
        m.instr(1, 2'h0);
        wr(8'h10, 32'h48);
        rdc(8'h10, 32'h48);
        rdc(8'h14, 32'h3);
    endtask : t_guard
    task t_sense();
        logic f02, r02, f13, r13;
        logic [3:0] lo, hi;
        for (int c = 0; c < 4; c++) for (int i = 0; i < 2; i++) begin
            wr(8'h10, {24'h0, c[1:0], i[0], c[1:0], i[0], 2'h0});
            f02 = (c == 3) || ((c == 1) == (i == 1));
            r02 = (c == 3) || ((c == 1) != (i == 1));
            f13 = c != 1;
            r13 = c[0];
            lo = {c == 0, c == 0 && i == 0, c == 0, c == 0 && i == 0};
            hi = {1'b0, c == 0 && i == 1, 1'b0, c == 0 && i == 1};
            for (int d = 0; d < 2; d++) begin
                m.lines(d ? 4'h0 : 4'hF);
                repeat (8) @(posedge clk_in);
                m.ack();
                repeat (2) @(posedge clk_in);
                m.lines(d ? 4'hF : 4'h0);
                repeat (6) @(posedge clk_in);
                chk(req, d ? {r13, r02, r13, r02} : {f13, f02, f13, f02});
                m.ack();
                repeat (3) @(posedge clk_in);
                chk(req, d ? hi : lo);
            end
        end
    endtask : t_sense
    task t_clear();
        wr(8'h10, 32'hD8);
        m.lines(4'h0);
        repeat (6) @(posedge clk_in);
        chk(req, 4'hF);
        wr(8'h10, 32'hD8);
        repeat (2) @(posedge clk_in);
        chk(req, 4'hF);
        wr(8'h10, 32'hFC);
        repeat (2) @(posedge clk_in);
        chk(req, 4'h0);
    endtask : t_clear
    initial begin
        repeat (10) @(posedge clk_in);
        reset_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        t_reset();
        t_prio();
        t_instr();
        t_map();
        t_reenter();
        t_guard();
        t_sense();
        t_clear();
        give_verdict();
    end
endmodule : test_irq_priority_and_ext_sensitivity
`default_nettype wire
